// File: design/adtr_map.vh
// register offsets, field positions and reset values of the converter regs
`ifndef ADTR_MAP_VH
`define ADTR_MAP_VH

`define ADTR_OFF_CTRL0      12'h000
`define ADTR_OFF_CTRL1      12'h004
`define ADTR_OFF_CTRL2      12'h008
`define ADTR_OFF_RES_HIGH   12'h00C
`define ADTR_OFF_RES_LOW    12'h010

`define ADTR_CTRL0_ON_BIT   0
`define ADTR_CTRL0_RUN_BIT  1
`define ADTR_CTRL0_CHS_LSB  2
`define ADTR_CTRL0_CHS_MSB  6
`define ADTR_CTRL1_JUST_BIT 7
`define ADTR_CTRL1_CS_LSB   4
`define ADTR_CTRL1_CS_MSB   6
`define ADTR_CTRL1_REF_LSB  0
`define ADTR_CTRL1_REF_MSB  1
`define ADTR_CTRL2_TRIG_LSB 4
`define ADTR_CTRL2_TRIG_MSB 6

`define ADTR_CTRL0_RESET    8'h00
`define ADTR_CTRL1_RESET    8'h00
`define ADTR_CTRL2_RESET    8'h00
`define ADTR_CTRL0_MASK     8'h7F
`define ADTR_CTRL1_MASK     8'hF3
`define ADTR_CTRL2_MASK     8'h70

`define ADTR_TRIG_NONE      3'h0
`define ADTR_TRIG_TIMER_ZERO      3'h3
`define ADTR_TRIG_TIMER_ONE      3'h4
`define ADTR_TRIG_TIMER_TWO      3'h5
`define ADTR_TRIG_CMP1      3'h6
`define ADTR_TRIG_CMP2      3'h7

`endif

// File: design/adtr_edge.v
// rising edge detector for the selected trigger source
`timescale 1ns/10ps
module adtr_edge (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // level in, pulse out
  input  wire level_in,
  output reg  rise_pulse
);

  reg prev_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg   <= 1'b0;
      rise_pulse <= 1'b0;
    end else begin
      prev_reg   <= level_in;
      rise_pulse <= level_in & ~prev_reg;
    end
  end

endmodule

// File: design/adtr_regs.v
// converter trigger selection, run flag and result registers on apb
`timescale 1ns/10ps
`include "adtr_map.vh"
module adtr_regs (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // power-on or brown-out reset, active low, synchronous
  input  wire        por_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // trigger sources
  input  wire        timer_zero_ovf,
  input  wire        timer_one_ovf,
  input  wire        timer_two_match,
  input  wire        synced_comparator_one_out,
  input  wire        synced_comparator_two_out,
  // converter core
  input  wire        conv_complete,
  input  wire [9:0]  conversion_result,
  output reg         conv_run,
  output reg         conv_enable,
  output reg  [4:0]  input_channel_select,
  output reg  [2:0]  conv_clock_select,
  output reg  [1:0]  pos_ref_select,
  output reg         result_justify_select,
  output reg         conversion_done_flag
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg  [7:0] ctrl0_reg;
  reg  [7:0] ctrl1_reg;
  reg  [7:0] ctrl2_reg;
  reg  [7:0] res_high_reg;
  reg  [7:0] res_low_reg;
  reg        run_reg;
  reg        trig_level;
  wire       trig_rise;
  wire [2:0] trig_sel;
  wire       wr_en;
  wire       rd_en;
  wire       addr_ok;
  wire       sw_start;
  wire       hw_start;

  assign trig_sel = ctrl2_reg[`ADTR_CTRL2_TRIG_MSB:`ADTR_CTRL2_TRIG_LSB];
  assign wr_en    = psel & penable & pwrite & pready;
  assign rd_en    = psel & ~penable & ~pwrite;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function valid_addr;
    input [11:0] a;
    begin
      valid_addr = (a == `ADTR_OFF_CTRL0) | (a == `ADTR_OFF_CTRL1) |
                   (a == `ADTR_OFF_CTRL2) | (a == `ADTR_OFF_RES_HIGH) |
                   (a == `ADTR_OFF_RES_LOW);
    end
  endfunction

  // merge write data into an 8-bit register under byte lane 0
  function [7:0] wmerge;
    input [7:0] old;
    input [7:0] mask;
    begin
      wmerge = pstrb[0] ? (pwdata[7:0] & mask) : old;
    end
  endfunction

  assign addr_ok = valid_addr(paddr);

  // ------------------------------------------------------------
  // trigger selection and edge detection
  // ------------------------------------------------------------
  always @* begin
    case (trig_sel)
      `ADTR_TRIG_TIMER_ZERO: trig_level = timer_zero_ovf;
      `ADTR_TRIG_TIMER_ONE: trig_level = timer_one_ovf;
      `ADTR_TRIG_TIMER_TWO: trig_level = timer_two_match;
      `ADTR_TRIG_CMP1: trig_level = synced_comparator_one_out;
      `ADTR_TRIG_CMP2: trig_level = synced_comparator_two_out;
      default:         trig_level = 1'b0;
    endcase
  end

  adtr_edge u_edge (
    .pclk       (pclk),
    .presetn    (presetn),
    .level_in   (trig_level),
    .rise_pulse (trig_rise)
  );

  // timer events go to their own flags untouched; only observed here
  assign hw_start = trig_rise & ctrl0_reg[`ADTR_CTRL0_ON_BIT];
  assign sw_start = wr_en & (paddr == `ADTR_OFF_CTRL0) & pstrb[0] &
                    pwdata[`ADTR_CTRL0_RUN_BIT];

  // ------------------------------------------------------------
  // apb handshake: no wait states, pready in every access cycle, writes take effect at pready
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      if (rd_en) begin
        case (paddr)
          `ADTR_OFF_CTRL0:
            prdata <= {24'h00_0000, ctrl0_reg[7:2], run_reg,
                       ctrl0_reg[0]};
          `ADTR_OFF_CTRL1:    prdata <= {24'h00_0000, ctrl1_reg};
          `ADTR_OFF_CTRL2:    prdata <= {24'h00_0000, ctrl2_reg};
          `ADTR_OFF_RES_HIGH: prdata <= {24'h00_0000, res_high_reg};
          `ADTR_OFF_RES_LOW:  prdata <= {24'h00_0000, res_low_reg};
          default:            prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // control registers, cleared by presetn only, not by por_n
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_reg <= `ADTR_CTRL0_RESET;
      ctrl1_reg <= `ADTR_CTRL1_RESET;
      ctrl2_reg <= `ADTR_CTRL2_RESET;
    end else if (wr_en) begin
      case (paddr)
        `ADTR_OFF_CTRL0:
          ctrl0_reg <= wmerge(ctrl0_reg, `ADTR_CTRL0_MASK);
        `ADTR_OFF_CTRL1:
          ctrl1_reg <= wmerge(ctrl1_reg, `ADTR_CTRL1_MASK);
        `ADTR_OFF_CTRL2:
          ctrl2_reg <= wmerge(ctrl2_reg, `ADTR_CTRL2_MASK);
        default: ctrl0_reg <= ctrl0_reg;
      endcase
    end
  end

  // ------------------------------------------------------------
  // run flag: set by software or trigger edge, cleared on completion
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= 1'b0;
    end else if (!ctrl0_reg[`ADTR_CTRL0_ON_BIT]) begin
      run_reg <= 1'b0;
    end else if (hw_start) begin
      run_reg <= 1'b1;
    end else if (sw_start) begin
      run_reg <= 1'b1;
    end else if (conv_complete & run_reg) begin
      run_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // result registers: no async reset, cleared only by por_n
  // ------------------------------------------------------------
  always @(posedge pclk) begin
    if (!por_n) begin
      res_high_reg <= 8'h00;
      res_low_reg  <= 8'h00;
    end else if (conv_complete & run_reg) begin
      if (ctrl1_reg[`ADTR_CTRL1_JUST_BIT]) begin
        res_high_reg <= {6'h00, conversion_result[9:8]};
        res_low_reg  <= conversion_result[7:0];
      end else begin
        res_high_reg <= conversion_result[9:2];
        res_low_reg  <= {conversion_result[1:0], 6'h00};
      end
    end else if (wr_en & (paddr == `ADTR_OFF_RES_HIGH)) begin
      res_high_reg <= wmerge(res_high_reg, 8'hFF);
    end else if (wr_en & (paddr == `ADTR_OFF_RES_LOW)) begin
      res_low_reg <= wmerge(res_low_reg, 8'hFF);
    end
  end

  // ------------------------------------------------------------
  // registered outputs to converter core
  // no hold-node discharge command exists after a conversion
  // channel change settling is left to software
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_run              <= 1'b0;
      conv_enable           <= 1'b0;
      input_channel_select  <= 5'h00;
      conv_clock_select     <= 3'h0;
      pos_ref_select        <= 2'h0;
      result_justify_select <= 1'b0;
      conversion_done_flag  <= 1'b0;
    end else begin
      conv_run              <= run_reg;
      conv_enable           <= ctrl0_reg[`ADTR_CTRL0_ON_BIT];
      input_channel_select  <=
        ctrl0_reg[`ADTR_CTRL0_CHS_MSB:`ADTR_CTRL0_CHS_LSB];
      conv_clock_select     <=
        ctrl1_reg[`ADTR_CTRL1_CS_MSB:`ADTR_CTRL1_CS_LSB];
      pos_ref_select        <=
        ctrl1_reg[`ADTR_CTRL1_REF_MSB:`ADTR_CTRL1_REF_LSB];
      result_justify_select <= ctrl1_reg[`ADTR_CTRL1_JUST_BIT];
      conversion_done_flag  <= conv_complete & run_reg;
    end
  end

endmodule

// File: sim/adtr_regs_assertions.sv
// checker for the converter trigger and result register block
`timescale 1ns/10ps
module adtr_chk (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // converter
  input wire        timer_zero_ovf,
  input wire        timer_one_ovf,
  input wire        timer_two_match,
  input wire        synced_comparator_one_out,
  input wire        synced_comparator_two_out,
  input wire        conv_complete,
  input wire        conv_run,
  input wire        conversion_done_flag
);
  // ----
  // shadow of trigger code and enable
  // ----
  reg  [2:0] trig_q;
  reg        on_q;
  wire       wr = psel & penable & pready & pwrite & pstrb[0];
  wire       run_wr = wr & (paddr == 12'h000) & pwdata[1];
  wire [7:0] srcs = {synced_comparator_two_out, synced_comparator_one_out,
                     timer_two_match, timer_one_ovf, timer_zero_ovf, 3'h0};
  wire       sel = srcs[trig_q];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_q <= 3'h0;
      on_q   <= 1'b0;
    end else if (wr) begin
      if (paddr == 12'h008)
        trig_q <= pwdata[6:4];
      if (paddr == 12'h000)
        on_q <= pwdata[0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  sequence src_rise_s;
    $rose(sel) && on_q && !conv_run && !conv_complete;
  endsequence
  a_ready_setup: assert property (setup_s |=> access_s)
    else $error("no ready in access cycle");
  a_ready_single: assert property (access_s |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (pready && paddr > 12'h010 |->
    pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  a_ctrl2_zeros: assert property (pready && !pwrite && paddr == 12'h008 |->
    (prdata & ~32'h70) == 32'h0) else $error("trigger reg stray bits");
  a_done_cause: assert property (conversion_done_flag |->
    $past(conv_complete)) else $error("done flag without completion");
  a_trig_start: assert property (src_rise_s |-> ##[1:4] conv_run)
    else $error("trigger edge did not start");
  a_no_false: assert property ($rose(conv_run) |->
    trig_q > 3'h2 || $past(run_wr, 2)) else $error("start without cause");
  a_run_clears: assert property ($fell(conv_run) |->
    $past(conv_complete, 2) || !on_q) else $error("run cleared early");
endmodule
bind adtr_regs adtr_chk u_adtr_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .timer_zero_ovf, .timer_one_ovf, .timer_two_match,
  .synced_comparator_one_out, .synced_comparator_two_out, .conv_complete,
  .conv_run, .conversion_done_flag);

// File: sim/test_adtr_regs.sv
// self-checking bench for the converter trigger and result registers
`timescale 1ns/10ps
module test_adtr_regs;
  reg          pclk, presetn, por_n, psel, penable, pwrite, conv_complete;
  reg  [11:0]  paddr;
  reg  [31:0]  pwdata;
  reg  [4:0]   src;
  reg  [9:0]   conversion_result;
  wire [31:0]  prdata;
  wire         pready;
  wire         done;
  logic [31:0] expq[$];
  logic [9:0]  r;
  logic        j;
  logic [7:0]  hi, lo;
  int          bad_count, total_checks, c;
  adtr_regs u_adtr_regs (.pclk, .presetn, .por_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr(),
    .timer_zero_ovf(src[0]), .timer_one_ovf(src[1]),
    .timer_two_match(src[2]), .synced_comparator_one_out(src[3]),
    .synced_comparator_two_out(src[4]), .conv_complete,
    .conversion_result, .conv_run(), .conv_enable(),
    .input_channel_select(), .conv_clock_select(), .pos_ref_select(),
    .result_justify_select(), .conversion_done_flag(done));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ----
  // checking and apb tasks
  // ----
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
      chk("prdata", prdata, expq.pop_front());
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // look at pready while it stands, then take the accepting edge
    @(negedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(negedge pclk);
    end
    if (n >= 20)
      bad_count++;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    test_done;
  end
  initial begin
    {presetn, por_n, psel, penable, pwrite, conv_complete} = 6'h0;
    {paddr, pwdata, src, conversion_result} = 59'h0;
    r = 10'($urandom(32'h5441));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge pclk);
    {hi, lo} = 16'h0;
    rd(12'h008, 32'h0);
    apb(1'b1, 12'h008, 32'hFF);
    rd(12'h008, 32'h70);
    rd(12'h020, 32'h0);
    apb(1'b1, 12'h000, 32'h1);
    $display("test registers done");
    for (c = 0; c < 8; c++) begin
      r = 10'($urandom);
      j = 1'($urandom);
      apb(1'b1, 12'h008, c << 4);
      apb(1'b1, 12'h004, {24'h0, j, 7'h0});
      src <= c < 3 ? 5'h1F : ~(5'h1 << (c - 3));
      repeat (4) @(posedge pclk);
      rd(12'h000, 32'h1);
      src <= 5'h1F;
      repeat (4) @(posedge pclk);
      rd(12'h000, c < 3 ? 32'h1 : 32'h3);
      conversion_result <= r;
      conv_complete <= 1'b1;
      @(posedge pclk);
      conv_complete <= 1'b0;
      @(negedge pclk);
      chk("done", {31'h0, done}, c > 2 ? 32'h1 : 32'h0);
      repeat (3) @(posedge pclk);
      if (c > 2) begin
        hi = j ? {6'h0, r[9:8]} : r[9:2];
        lo = j ? r[7:0] : {r[1:0], 6'h0};
      end
      rd(12'h000, 32'h1);
      rd(12'h00C, {24'h0, hi});
      rd(12'h010, {24'h0, lo});
      src <= 5'h0;
      @(posedge pclk);
    end
    $display("test triggers done");
    apb(1'b1, 12'h00C, 32'hA5);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h008, 32'h0);
    rd(12'h00C, 32'hA5);
    rd(12'h010, {24'h0, lo});
    por_n <= 1'b0;
    @(posedge pclk);
    por_n <= 1'b1;
    @(posedge pclk);
    rd(12'h00C, 32'h0);
    $display("test resets done");
    @(posedge pclk);
    test_done;
  end
endmodule
